// ===== shared/sacc_pkg.sv
/*
 * Shared constants and carriers for the subtractive accumulator adder.
 * Assumes a single 125 MHz clock domain and a sequence controller that drives
 * the strobe group synchronously to that clock.
 */
`default_nettype none

package sacc_pkg;

    // Datapath geometry
    localparam int          SACC_HALF_W     = 36;
    localparam int          SACC_ACC_W      = 2 * SACC_HALF_W;
    localparam int          SACC_SIGN_POS   = SACC_HALF_W - 1;

    // Register port geometry and offsets
    localparam int          SACC_ADDR_W     = 4;
    localparam int          SACC_DATA_W     = 36;
    localparam logic [3:0]  SACC_OFS_OPND   = 4'h0;
    localparam logic [3:0]  SACC_OFS_ACC_LO = 4'h4;
    localparam logic [3:0]  SACC_OFS_ACC_HI = 4'h8;
    localparam logic [3:0]  SACC_OFS_STATUS = 4'hC;

    // Status field positions
    localparam int          SACC_ST_READY   = 0;
    localparam int          SACC_ST_ARMED   = 1;
    localparam int          SACC_ST_UPPER   = 2;

    // Reset values
    localparam logic [35:0] SACC_OPND_RST   = 36'h0_0000_0000;
    localparam logic [71:0] SACC_ACC_RST    = 72'h00_0000_0000_0000_0000;

    // Strobes and clock pulses issued by the sequence controller
    typedef struct packed {
        logic operand_transfer;     // Toggle lower stages under operand zeros
        logic upper_toggle;         // Toggle every upper stage
        logic clock_pulse;          // Controlled clock pulse, raises the probes
        logic decrement;            // Inject a borrow into stage 0
        logic operand_complement;   // Invert the operand register
    } sacc_strobe_t;

    // Sequencing states of the accumulator
    typedef enum logic [1:0] {
        SACC_IDLE,
        SACC_ARMED,
        SACC_RESOLVE
    } sacc_state_t;

endpackage : sacc_pkg

`default_nettype wire

// ===== hdl/sacc_toggle.sv
/*
 * One accumulator half: the bitwise toggle under a mask and the borrow gates.
 * Assumes the caller chooses the mask: operand zeros for the lower half, all
 * ones or all zeros for the upper half.
 */
`timescale 1ns/1ps
`default_nettype none

module sacc_toggle
    import sacc_pkg::*;
#(
    parameter int W = SACC_HALF_W
)
(
    input  wire logic [W-1:0] stage_in,
    input  wire logic [W-1:0] zero_mask_in,
    output logic      [W-1:0] toggled_out,
    output logic      [W-1:0] borrow_gate_out
);

    // Per-stage toggle and borrow gate
    for (genvar i = 0; i < W; i++)
    begin : g_stage
        assign toggled_out[i]     = stage_in[i] ^ zero_mask_in[i];
        assign borrow_gate_out[i] = stage_in[i] & zero_mask_in[i];
    end

endmodule : sacc_toggle

`default_nettype wire

// ===== hdl/sacc_wave.sv
/*
 * One wave of borrow propagation across the whole circular accumulator.
 * Assumes pending_in marks stages that receive a borrow in this wave.
 */
`timescale 1ns/1ps
`default_nettype none

module sacc_wave
    import sacc_pkg::*;
#(
    parameter int W = SACC_ACC_W
)
(
    input  wire logic [W-1:0] acc_in,
    input  wire logic [W-1:0] pending_in,
    output logic      [W-1:0] acc_out,
    output logic      [W-1:0] pending_out
);

    // Rapid borrow leaves a stage that held zero; the top stage wraps to stage 0
    for (genvar i = 0; i < W; i++)
    begin : g_stage
        localparam int NXT = (i + 1) % W;
        assign acc_out[i]       = acc_in[i] ^ pending_in[i];
        assign pending_out[NXT] = pending_in[i] & ~acc_in[i];
    end

endmodule : sacc_wave

`default_nettype wire

// ===== hdl/sacc_top.sv
/*
 * Subtractive one's-complement accumulator adder with a 36-bit operand.
 * Assumes the sequence controller issues strobes one cycle long, synchronous
 * to clk_in, and waits for ready_out before each new strobe.
 */
//
// Notes on behaviour
// - The accumulator is 72 stages in two 36-stage halves; only the lower half sees the operand.
// - The transfer strobe toggles each lower stage whose operand bit is zero, the rest stay.
// - Transfer plus borrows leaves the one's-complement sum of accumulator and operand.
// - Ordinary addition sign-extends the operand from bit 35 up to bit 71.
// - With operand bit 35 at zero the upper strobe comes too and toggles all upper stages.
// - Lower borrow gates open on stage one and operand zero; upper gates open on stage one only while armed.
// - Every stage opens its rapid-borrow gate while it holds zero.
// - The first clock pulse after the transfer raises the lower probe, and the upper if armed.
// - A probe samples every borrow gate of its half; open gates borrow into the next stage.
// - An incoming borrow samples the rapid gate, toggles the stage, and passes on from a zero.
// - A rapid borrow acts exactly like a borrow in the next stage, so it can keep going.
// - Both halves generate borrows together and a borrow out of stage 71 enters stage 0.
// - Split addition treats the operand as unsigned, so the upper strobe always comes.
// - Controlled complement inverts the operand, transfers it, and has no probes.
// - Subtraction inverts the operand first and then runs as the matching addition.
// - The decrement command injects a borrow into stage 0 that behaves like any other.
`timescale 1ns/1ps
`default_nettype none

module sacc_top
    import sacc_pkg::*;
#(
    parameter int HALF_W = SACC_HALF_W
)
(
    input  wire logic                     clk_in,
    input  wire logic                     arst_n_in,
    // Sequence controller side
    input  wire sacc_strobe_t             strobe_in,
    output logic                          ready_out,
    output logic                          armed_out,
    output logic [2*HALF_W-1:0]           acc_out,
    output logic [HALF_W-1:0]             operand_out,
    // Register port
    input  wire logic [SACC_ADDR_W-1:0]   reg_addr_in,
    input  wire logic [SACC_DATA_W-1:0]   reg_wr_data_in,
    input  wire logic                     reg_wr_in,
    input  wire logic                     reg_rd_in,
    output logic      [SACC_DATA_W-1:0]   reg_rd_data_out
);

    localparam int ACC_W = 2 * HALF_W;

    // Refuse geometries the register port cannot carry
    if (HALF_W < 2 || HALF_W > SACC_DATA_W)
    begin : g_bad_width
        $error("sacc_top: HALF_W must lie between 2 and the register data width");
    end

    // Refuse status fields that fall outside the data word
    if (SACC_ST_UPPER >= SACC_DATA_W || SACC_ST_ARMED >= SACC_DATA_W)
    begin : g_bad_status
        $error("sacc_top: status fields must lie inside the register data word");
    end

    // Refuse an accumulator wider than its reset constant
    if (ACC_W > $bits(SACC_ACC_RST))
    begin : g_bad_reset
        $error("sacc_top: accumulator is wider than its reset value");
    end

    // State
    sacc_state_t           state_reg;
    sacc_state_t           state_next;
    logic [HALF_W-1:0]     operand_reg;
    logic [HALF_W-1:0]     operand_next;
    logic [ACC_W-1:0]      acc_reg;
    logic [ACC_W-1:0]      acc_next;
    logic [ACC_W-1:0]      pending_reg;
    logic [ACC_W-1:0]      pending_next;
    logic                  upper_armed_reg;
    logic                  upper_armed_next;
    logic [SACC_DATA_W-1:0] rd_data_reg;
    logic [SACC_DATA_W-1:0] rd_data_next;

    // Accumulator halves
    wire  [HALF_W-1:0]     lower_word = acc_reg[HALF_W-1:0];
    wire  [HALF_W-1:0]     upper_word = acc_reg[ACC_W-1:HALF_W];

    // Strobe qualification: nothing is taken while borrows are in flight
    wire                   accepting  = (state_reg != SACC_RESOLVE);
    wire                   do_xfer    = accepting & strobe_in.operand_transfer;
    wire                   do_upper   = do_xfer & strobe_in.upper_toggle;
    wire                   do_probe   = (state_reg == SACC_ARMED) & strobe_in.clock_pulse
                                        & ~strobe_in.operand_transfer;
    wire                   do_decr    = accepting & strobe_in.decrement
                                        & ~strobe_in.operand_transfer & ~do_probe;
    wire                   do_cmpl    = accepting & strobe_in.operand_complement
                                        & ~strobe_in.operand_transfer;

    // Register port decode
    wire                   wr_opnd    = reg_wr_in & (reg_addr_in == SACC_OFS_OPND);
    wire                   wr_acc_lo  = reg_wr_in & (reg_addr_in == SACC_OFS_ACC_LO);
    wire                   wr_acc_hi  = reg_wr_in & (reg_addr_in == SACC_OFS_ACC_HI);
    wire                   sw_opnd_ok = wr_opnd & accepting & ~do_cmpl & ~do_xfer;
    wire                   sw_acc_ok  = accepting & ~do_xfer & ~do_probe & ~do_decr;

    // Toggle masks: operand zeros below, the upper strobe or the armed flag above
    wire  [HALF_W-1:0]     lower_mask = ~operand_reg;
    wire                   upper_sel  = do_xfer ? strobe_in.upper_toggle : upper_armed_reg;
    wire  [HALF_W-1:0]     upper_mask = {HALF_W{upper_sel}};

    wire  [HALF_W-1:0]     lower_toggled;
    wire  [HALF_W-1:0]     lower_gate;
    wire  [HALF_W-1:0]     upper_toggled;
    wire  [HALF_W-1:0]     upper_gate;

    // Lower half: toggle under operand zeros, gates on stage one with operand zero
    sacc_toggle #(
        .W               (HALF_W)
    ) u_lower (
        .stage_in        (lower_word),
        .zero_mask_in    (lower_mask),
        .toggled_out     (lower_toggled),
        .borrow_gate_out (lower_gate)
    );

    // Upper half: whole-word toggle, gates on stage one when armed
    sacc_toggle #(
        .W               (HALF_W)
    ) u_upper (
        .stage_in        (upper_word),
        .zero_mask_in    (upper_mask),
        .toggled_out     (upper_toggled),
        .borrow_gate_out (upper_gate)
    );

    // Probe: both halves sample their gates at once, borrows move one stage up
    wire  [ACC_W-1:0]      gates      = {upper_gate, lower_gate};
    wire  [ACC_W-1:0]      probe_brw  = {gates[ACC_W-2:0], gates[ACC_W-1]};

    // Decrement borrow enters stage 0 as an ordinary borrow
    wire  [ACC_W-1:0]      decr_brw   = {{(ACC_W-1){1'b0}}, 1'b1};

    wire  [ACC_W-1:0]      wave_acc;
    wire  [ACC_W-1:0]      wave_pending;

    // One borrow wave per cycle: toggle receivers, rapid borrows from former zeros
    sacc_wave #(
        .W           (ACC_W)
    ) u_wave (
        .acc_in      (acc_reg),
        .pending_in  (pending_reg),
        .acc_out     (wave_acc),
        .pending_out (wave_pending)
    );

    wire                   settled    = (wave_pending == '0);

    // Next operand: software load, or inversion before a transfer
    always_comb
    begin
        operand_next = operand_reg;
        if (do_cmpl)
        begin
            operand_next = ~operand_reg;
        end
        else if (sw_opnd_ok)
        begin
            operand_next = reg_wr_data_in[HALF_W-1:0];
        end
    end

    // Next accumulator, borrow vector, armed flag and state
    always_comb
    begin
        acc_next         = acc_reg;
        pending_next     = pending_reg;
        upper_armed_next = upper_armed_reg;
        state_next       = state_reg;
        case (state_reg)
            SACC_IDLE, SACC_ARMED:
            begin
                if (do_xfer)
                begin
                    // Lower toggle always; upper toggle only with its strobe
                    acc_next[HALF_W-1:0]     = lower_toggled;
                    acc_next[ACC_W-1:HALF_W] = do_upper ? upper_toggled
                                                        : upper_word;
                    upper_armed_next         = do_upper;
                    state_next               = SACC_ARMED;
                end
                else if (do_probe)
                begin
                    pending_next     = probe_brw;
                    upper_armed_next = 1'b0;
                    state_next       = SACC_RESOLVE;
                end
                else if (do_decr)
                begin
                    // A decrement in the armed state drops the pending probe
                    pending_next     = decr_brw;
                    upper_armed_next = 1'b0;
                    state_next       = SACC_RESOLVE;
                end
                else
                begin
                    if (sw_acc_ok && wr_acc_lo)
                    begin
                        acc_next[HALF_W-1:0] = reg_wr_data_in[HALF_W-1:0];
                    end
                    if (sw_acc_ok && wr_acc_hi)
                    begin
                        acc_next[ACC_W-1:HALF_W] = reg_wr_data_in[HALF_W-1:0];
                    end
                end
            end
            SACC_RESOLVE:
            begin
                // Each borrow samples the rapid gate, then toggles its stage
                acc_next     = wave_acc;
                pending_next = wave_pending;
                if (settled)
                begin
                    state_next = SACC_IDLE;
                end
            end
            default:
            begin
                state_next = SACC_IDLE;
            end
        endcase
    end

    // Status word
    wire  [SACC_DATA_W-1:0] status_word =
        (SACC_DATA_W'(accepting)                         << SACC_ST_READY)
      | (SACC_DATA_W'(state_reg == SACC_ARMED)           << SACC_ST_ARMED)
      | (SACC_DATA_W'(upper_armed_reg)                   << SACC_ST_UPPER);

    // Read selection; unmapped addresses read as zero
    logic [SACC_DATA_W-1:0] rd_sel;
    always_comb
    begin
        if (reg_addr_in == SACC_OFS_OPND)
        begin
            rd_sel = SACC_DATA_W'(operand_reg);
        end
        else if (reg_addr_in == SACC_OFS_ACC_LO)
        begin
            rd_sel = SACC_DATA_W'(lower_word);
        end
        else if (reg_addr_in == SACC_OFS_ACC_HI)
        begin
            rd_sel = SACC_DATA_W'(upper_word);
        end
        else if (reg_addr_in == SACC_OFS_STATUS)
        begin
            rd_sel = status_word;
        end
        else
        begin
            rd_sel = '0;
        end
    end

    // Read data stand only in the cycle after the read strobe
    assign rd_data_next = reg_rd_in ? rd_sel : '0;

    // State registers
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_reg       <= SACC_IDLE;
            operand_reg     <= SACC_OPND_RST[HALF_W-1:0];
            acc_reg         <= SACC_ACC_RST[ACC_W-1:0];
            pending_reg     <= '0;
            upper_armed_reg <= 1'b0;
        end
        else
        begin
            state_reg       <= state_next;
            operand_reg     <= operand_next;
            acc_reg         <= acc_next;
            pending_reg     <= pending_next;
            upper_armed_reg <= upper_armed_next;
        end
    end

    // Read data register
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rd_data_reg <= '0;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
        end
    end

    // Outputs
    assign ready_out       = accepting;
    assign armed_out       = (state_reg == SACC_ARMED);
    assign acc_out         = acc_reg;
    assign operand_out     = operand_reg;
    assign reg_rd_data_out = rd_data_reg;

endmodule : sacc_top

`default_nettype wire

// ===== tb/sacc_top_properties.sv
/*
 * Port checker for the subtractive accumulator adder, bound into sacc_top.
 * Assumes one clock domain and strobes that last one cycle each.
 */
`timescale 1ns/1ps
`default_nettype none

module sacc_props
    import sacc_pkg::*;
#(
    parameter int HALF_W = SACC_HALF_W
)
(
    input wire logic                clk_in,
    input wire logic                arst_n_in,
    input wire sacc_strobe_t        strobe_in,
    input wire logic                ready_out,
    input wire logic                armed_out,
    input wire logic [2*HALF_W-1:0] acc_out,
    input wire logic [HALF_W-1:0]   operand_out,
    input wire logic                reg_wr_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // Strobes as the block takes them
    wire logic xfer_w  = strobe_in.operand_transfer && ready_out;
    wire logic probe_w = strobe_in.clock_pulse && armed_out && ready_out
                         && !strobe_in.operand_transfer;
    wire logic dec_w   = strobe_in.decrement && ready_out && !strobe_in.operand_transfer
                         && !probe_w;

    property p_xfer_lower;
        xfer_w |=> acc_out[HALF_W-1:0] == ($past(acc_out[HALF_W-1:0]) ^ ~$past(operand_out));
    endproperty
    a_xfer_lower: assert property (p_xfer_lower) else $error("lower toggle wrong");
    property p_upper_toggle;
        xfer_w && strobe_in.upper_toggle
            |=> acc_out[2*HALF_W-1:HALF_W] == ~$past(acc_out[2*HALF_W-1:HALF_W]);
    endproperty
    a_upper_toggle: assert property (p_upper_toggle) else $error("upper toggle wrong");
    property p_upper_hold;
        xfer_w && !strobe_in.upper_toggle |=> $stable(acc_out[2*HALF_W-1:HALF_W]);
    endproperty
    a_upper_hold: assert property (p_upper_hold) else $error("upper half moved");
    property p_arm;
        xfer_w |=> armed_out && ready_out;
    endproperty
    a_arm: assert property (p_arm) else $error("transfer did not arm");
    property p_probe;
        probe_w |=> !ready_out && !armed_out;
    endproperty
    a_probe: assert property (p_probe) else $error("probe not started");
    property p_dec;
        dec_w |=> !ready_out;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement not started");
    property p_settle;
        $fell(ready_out) |-> ##[1:80] ready_out;
    endproperty
    a_settle: assert property (p_settle) else $error("borrows never settled");
    property p_refuse;
        !ready_out |=> $stable(operand_out) && !armed_out;
    endproperty
    a_refuse: assert property (p_refuse) else $error("strobe taken while busy");
    property p_compl;
        strobe_in.operand_complement && ready_out && !strobe_in.operand_transfer
            |=> operand_out == ~$past(operand_out);
    endproperty
    a_compl: assert property (p_compl) else $error("operand not inverted");
    property p_quiet;
        ready_out && !strobe_in.operand_transfer && !strobe_in.decrement && !probe_w
            && !reg_wr_in |=> $stable(acc_out);
    endproperty
    a_quiet: assert property (p_quiet) else $error("accumulator moved unasked");

    // Main scenarios reached
    c_probe: cover property (probe_w);
    c_dec: cover property (dec_w);
    c_long: cover property (!ready_out [*8]);
endmodule : sacc_props

bind sacc_top sacc_props #(.HALF_W(HALF_W)) u_sacc_props (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .strobe_in(strobe_in), .ready_out(ready_out),
    .armed_out(armed_out), .acc_out(acc_out), .operand_out(operand_out),
    .reg_wr_in(reg_wr_in));

`default_nettype wire

// ===== tb/sacc_seq_model.sv
/*
 * Behavioural sequence controller that issues the strobe group.
 * Assumes run_op is called at a rising edge of clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module sacc_seq_model
    import sacc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        ready_in,
    input  wire logic [35:0] operand_in,
    output var sacc_strobe_t strobe_out
);
    initial strobe_out = '0;

    // Waits until borrows settle, then idles for the gap
    task automatic wait_ready(input int gap);
        do @(posedge clk_in); while (ready_in !== 1'b1);
        repeat (gap) @(posedge clk_in);
    endtask : wait_ready

    // One-cycle strobe, released at the edge that takes it
    task automatic pulse(input sacc_strobe_t s);
        strobe_out <= s;
        @(posedge clk_in);
        strobe_out <= '0;
    endtask : pulse

    // Ops: 0 add, 1 split add, 2 sub, 3 split sub, 4 complement, 5 decrement
    task automatic run_op(input logic [2:0] op, input int gap);
        sacc_strobe_t s;
        s = '0;
        wait_ready(gap);
        if (op inside {3'h2, 3'h3, 3'h4})
        begin
            s.operand_complement = 1'b1;
            pulse(s);
            wait_ready(gap);
        end
        s = '0;
        if (op == 3'h5)
        begin
            s.decrement = 1'b1;
            pulse(s);
        end
        else
        begin
            s.operand_transfer = 1'b1;
            s.upper_toggle = (op != 3'h4) && (op[0] || !operand_in[35]);
            pulse(s);
            // Complement leaves out both probes
            if (op != 3'h4)
            begin
                s = '0;
                wait_ready(gap);
                s.clock_pulse = 1'b1;
                pulse(s);
            end
        end
        wait_ready(0);
    endtask : run_op
endmodule : sacc_seq_model

`default_nettype wire

// ===== tb/testbench.sv
/*
 * Self-checking bench for the subtractive accumulator adder.
 * Assumes the sequence model drives the strobes and the bench the register port.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench
    import sacc_pkg::*;
;
    logic         clk_in, arst_n_in, reg_wr_in, reg_rd_in, ready_out, armed_out, rd_q;
    sacc_strobe_t strobe_in;
    logic [71:0]  acc_out;
    logic [35:0]  operand_out, reg_wr_data_in, reg_rd_data_out;
    logic [3:0]   reg_addr_in;
    logic [35:0]  exp_q[$];
    int           errors, samples_checked;

    // 125 MHz clock
    initial clk_in = 1'b0;
    always #4 clk_in = ~clk_in;

    sacc_top #(.HALF_W(SACC_HALF_W)) u_sacc_top (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .strobe_in(strobe_in), .ready_out(ready_out), .armed_out(armed_out),
        .acc_out(acc_out), .operand_out(operand_out), .reg_addr_in(reg_addr_in),
        .reg_wr_data_in(reg_wr_data_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rd_data_out(reg_rd_data_out));
    sacc_seq_model u_sacc_seq_model (.clk_in(clk_in), .ready_in(ready_out),
        .operand_in(operand_out), .strobe_out(strobe_in));

    task automatic end_of_test;
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Read data stands one cycle after the read; compare with the oldest note
    always @(posedge clk_in)
    begin
        if (rd_q === 1'b1)
            check("reg_rd_data_out", reg_rd_data_out, exp_q.pop_front());
        rd_q <= reg_rd_in;
    end

    // One register access; a read notes data as its expected value
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [35:0] data);
        reg_wr_in      <= wr;
        reg_rd_in      <= !wr;
        reg_addr_in    <= addr;
        reg_wr_data_in <= data;
        if (!wr)
            exp_q.push_back(data);
        @(posedge clk_in);
    endtask : bus

    task automatic bus_idle;
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        @(posedge clk_in);
    endtask : bus_idle

    // Subtraction with the borrow out of the top wrapping into stage 0
    function automatic logic [71:0] sub72(input logic [71:0] a, input logic [71:0] b);
        logic [71:0] d;
        d = a - b;
        if (a < b)
            d = d - 72'h1;
        return d;
    endfunction : sub72

    task automatic run_case(input logic [2:0] op, input logic [71:0] a, input logic [35:0] x,
                            input int gap, input logic poke);
        logic [35:0] xe;
        logic [71:0] e;
        xe = (op inside {3'h2, 3'h3, 3'h4}) ? ~x : x;
        e  = (op == 3'h5) ? sub72(a, 72'h1) : sub72(a, {{36{op[0] || !xe[35]}}, ~xe});
        if (op == 3'h4)
            e = {a[71:36], a[35:0] ^ x};
        bus(1'b1, SACC_OFS_OPND, x);
        bus(1'b1, SACC_OFS_ACC_LO, a[35:0]);
        bus(1'b1, SACC_OFS_ACC_HI, a[71:36]);
        bus_idle();
        fork
            u_sacc_seq_model.run_op(op, gap);
            if (poke)
            begin
                repeat (6) @(posedge clk_in);
                bus(1'b1, SACC_OFS_OPND, ~x);
                bus(1'b1, SACC_OFS_ACC_LO, ~a[35:0]);
                bus_idle();
            end
        join
        bus(1'b0, SACC_OFS_ACC_LO, e[35:0]);
        bus(1'b0, SACC_OFS_ACC_HI, e[71:36]);
        bus(1'b0, SACC_OFS_OPND, (op == 3'h5) ? x : xe);
        bus(1'b0, SACC_OFS_STATUS, (op == 3'h4) ? 36'h3 : 36'h1);
        bus_idle();
    endtask : run_case

    // Main sequence
    initial
    begin
        logic [95:0] r;
        {arst_n_in, reg_wr_in, reg_rd_in, rd_q} = '0;
        reg_addr_in = 4'h0;
        reg_wr_data_in = 36'h0;
        errors = 0;
        samples_checked = 0;
        void'($urandom(64));
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        bus(1'b1, SACC_OFS_STATUS, 36'hF_FFFF_FFFF);
        bus(1'b0, SACC_OFS_ACC_HI, 36'h0);
        bus(1'b0, 4'h2, 36'h0);
        bus(1'b0, SACC_OFS_STATUS, 36'h1);
        bus_idle();
        run_case(3'h0, 72'h0, 36'h0_0000_0005, 0, 1'b0);
        run_case(3'h0, 72'h0, 36'hF_FFFF_FFFE, 1, 1'b0);
        run_case(3'h1, 72'h0, 36'h8_0000_0005, 0, 1'b0);
        run_case(3'h2, 72'h3, 36'h0_0000_0005, 2, 1'b0);
        run_case(3'h4, 72'hF0_0000_0000_F0F0_F0F0, 36'hF_0000_FFFF, 0, 1'b0);
        run_case(3'h5, 72'h0, 36'h1_2345_6789, 0, 1'b1);
        for (int i = 0; i < 12; i++)
        begin
            r = {$urandom(), $urandom(), $urandom()};
            run_case(3'(i % 6), r[71:0], r[95:60], int'($urandom() % 3), 1'b0);
        end
        repeat (2) @(posedge clk_in);
        end_of_test();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk_in);
        errors++;
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
